/* File: hw/urs_pkg.sv */
// Purpose: Shared constants and types for the UART reset-state register block
// Assumes: Byte-wide register port, registers at indices chosen for this block
// Notes: Reset values and register indices live here only
package urs_pkg;
    // Register indices on the plain port
    localparam logic [4:0] URS_INT_EN_ADDR = 5'h01;
    localparam logic [4:0] URS_INT_STAT_ADDR = 5'h02;
    localparam logic [4:0] URS_FIFO_CTL_ADDR = 5'h03;
    localparam logic [4:0] URS_LINE_CTL_ADDR = 5'h04;
    localparam logic [4:0] URS_MODEM_CTL_ADDR = 5'h05;
    localparam logic [4:0] URS_LINE_STAT_ADDR = 5'h06;
    localparam logic [4:0] URS_MODEM_STAT_ADDR = 5'h07;
    localparam logic [4:0] URS_SCRATCH_ADDR = 5'h08;
    localparam logic [4:0] URS_ENH_MODE_ADDR = 5'h09;
    localparam logic [4:0] URS_FIFO_LVL_ADDR = 5'h0a;
    localparam logic [4:0] URS_ENH_FEAT_ADDR = 5'h0b;
    localparam logic [4:0] URS_RES1_ADDR = 5'h0c;
    localparam logic [4:0] URS_RES2_ADDR = 5'h0d;
    localparam logic [4:0] URS_PAU1_ADDR = 5'h0e;
    localparam logic [4:0] URS_PAU2_ADDR = 5'h0f;
    localparam logic [4:0] URS_TRIG_ADDR = 5'h10;
    localparam logic [4:0] URS_DLL_ADDR = 5'h11;
    localparam logic [4:0] URS_DLH_ADDR = 5'h12;
    // Reset values
    localparam logic [7:0] URS_ZERO_RST = 8'h00;
    localparam logic [7:0] URS_INT_STAT_RST = 8'h01;
    localparam logic [7:0] URS_LINE_STAT_RST = 8'h60;
    localparam logic [7:0] URS_SCRATCH_RST = 8'hff;
    // Modem control bit positions
    localparam int URS_MCTL_DTR_BIT = 0;
    localparam int URS_MCTL_RTS_BIT = 1;
    localparam int URS_MCTL_OUT1_BIT = 2;
    localparam int URS_MCTL_OUT2_BIT = 3;
    // Edge count after reset at which synchronised pins are real
    localparam logic [1:0] URS_SETTLE_DONE = 2'h3;
    // Register port request
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } urs_req_type;
    // Pin levels driven out, all active low except tx
    typedef struct packed {
        logic tx;
        logic user_output_one_n;
        logic user_output_two_n;
        logic rts_n;
        logic dtr_n;
    } urs_pins_type;
endpackage

/* File: hw/urs_sync.sv */
// Purpose: Two-flop synchroniser for a bundle of pin levels
// Assumes: Inputs are asynchronous to clock
// Notes: First stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module urs_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    // First and second stage
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // Register both stages, constants on reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule
`default_nettype wire

/* File: hw/urs_regs.sv */
// Purpose: Reset-state register file and idle pin levels of a FIFO UART
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Modem inputs are active-low pins, synchronised before use
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

//Contract
// - Four read/write flow-character byte registers
// - Reset clears most registers, fixed status values
// - Modem status: deltas zero, upper inverted pins
// - Reset drives tx, outputs, rts, dtr high
// - Receive-ready high standard mode, float otherwise; code drives it high during reset and until the third edge after release
// - Transmit-ready, interrupt low standard, float otherwise; code drives them low during reset and until the third edge after release
module urs_regs (
    input wire logic clock,
    input wire logic rst,
    input wire urs_pkg::urs_req_type req,
    output logic [7:0] rdata,
    input wire logic isa_mode,
    input wire logic [3:0] modem_in_n,
    output urs_pkg::urs_pins_type pins,
    output logic receive_ready_n,
    output logic receive_ready_oe,
    output logic transmit_ready_n,
    output logic transmit_ready_oe,
    output logic irq,
    output logic irq_oe
);
    import urs_pkg::*;

    // Synchronised pin levels
    logic [3:0] modem_s;
    logic isa_s;
    // Register state and next values
    logic [7:0] int_en_r, int_en_nxt;
    logic [7:0] fifo_ctl_r, fifo_ctl_nxt;
    logic [7:0] line_ctl_r, line_ctl_nxt;
    logic [7:0] modem_ctl_r, modem_ctl_nxt;
    logic [7:0] scratch_r, scratch_nxt;
    logic [7:0] enh_mode_r, enh_mode_nxt;
    logic [7:0] enh_feat_r, enh_feat_nxt;
    logic [7:0] trig_r, trig_nxt;
    logic [7:0] dll_r, dll_nxt;
    logic [7:0] dlh_r, dlh_nxt;
    logic [7:0] flow_r [4];
    logic [7:0] flow_nxt [4];
    logic [3:0] mstat_prev_r, mstat_prev_nxt;
    logic [3:0] mstat_delta_r, mstat_delta_nxt;
    // Edges since reset release, saturating
    logic [1:0] settle_r, settle_nxt;
    logic [7:0] rdata_nxt;
    logic [7:0] mstat_val;
    urs_pins_type pins_nxt;
    logic rxr_oe_nxt, txr_oe_nxt;

    // Modem inputs and bus mode strap pass two flops
    urs_sync #(.WIDTH(5)) u_sync (
        .clock(clock),
        .rst(rst),
        .din({isa_mode, modem_in_n}),
        .dout({isa_s, modem_s})
    );

    // Modem status view: inverted pins above change flags
    always_comb begin
        mstat_val = {~modem_s, mstat_delta_r};
    end

    // Next register values from writes
    always_comb begin
        int_en_nxt = int_en_r;
        fifo_ctl_nxt = fifo_ctl_r;
        line_ctl_nxt = line_ctl_r;
        modem_ctl_nxt = modem_ctl_r;
        scratch_nxt = scratch_r;
        enh_mode_nxt = enh_mode_r;
        enh_feat_nxt = enh_feat_r;
        trig_nxt = trig_r;
        dll_nxt = dll_r;
        dlh_nxt = dlh_r;
        for (int i = 0; i < 4; i++) begin
            flow_nxt[i] = flow_r[i];
        end
        if (req.wr) begin
            case (req.addr)
                URS_INT_EN_ADDR: int_en_nxt = req.wdata;
                URS_FIFO_CTL_ADDR: fifo_ctl_nxt = req.wdata;
                URS_LINE_CTL_ADDR: line_ctl_nxt = req.wdata;
                URS_MODEM_CTL_ADDR: modem_ctl_nxt = req.wdata;
                URS_SCRATCH_ADDR: scratch_nxt = req.wdata;
                URS_ENH_MODE_ADDR: enh_mode_nxt = req.wdata;
                URS_ENH_FEAT_ADDR: enh_feat_nxt = req.wdata;
                URS_TRIG_ADDR: trig_nxt = req.wdata;
                URS_DLL_ADDR: dll_nxt = req.wdata;
                URS_DLH_ADDR: dlh_nxt = req.wdata;
                // Flow characters
                URS_RES1_ADDR: flow_nxt[0] = req.wdata;
                URS_RES2_ADDR: flow_nxt[1] = req.wdata;
                URS_PAU1_ADDR: flow_nxt[2] = req.wdata;
                URS_PAU2_ADDR: flow_nxt[3] = req.wdata;
                default: ;
            endcase
        end
    end

    // Count edges after release until the synchroniser holds real pin levels
    always_comb begin
        settle_nxt = settle_r;
        if (settle_r != URS_SETTLE_DONE) begin
            settle_nxt = settle_r + 2'h1;
        end
    end

    // Modem change flags: set by a pin change, cleared by a status read
    always_comb begin
        mstat_prev_nxt = modem_s;
        mstat_delta_nxt = mstat_delta_r;
        if (req.rd && req.addr == URS_MODEM_STAT_ADDR) begin
            mstat_delta_nxt = '0;
        end
        // Set wins over the clearing read; the synchroniser filling after
        // reset is no pin change, so flags wait until it has settled
        if (settle_r == URS_SETTLE_DONE) begin
            mstat_delta_nxt = mstat_delta_nxt | (mstat_prev_r ^ modem_s);
        end
    end

    // Read mux, unmapped reads return zero
    always_comb begin
        rdata_nxt = URS_ZERO_RST;
        if (req.rd) begin
            case (req.addr)
                URS_INT_EN_ADDR: rdata_nxt = int_en_r;
                URS_INT_STAT_ADDR: rdata_nxt = URS_INT_STAT_RST;
                URS_FIFO_CTL_ADDR: rdata_nxt = fifo_ctl_r;
                URS_LINE_CTL_ADDR: rdata_nxt = line_ctl_r;
                URS_MODEM_CTL_ADDR: rdata_nxt = modem_ctl_r;
                URS_LINE_STAT_ADDR: rdata_nxt = URS_LINE_STAT_RST;
                URS_MODEM_STAT_ADDR: rdata_nxt = mstat_val;
                URS_SCRATCH_ADDR: rdata_nxt = scratch_r;
                URS_ENH_MODE_ADDR: rdata_nxt = enh_mode_r;
                URS_FIFO_LVL_ADDR: rdata_nxt = URS_ZERO_RST;
                URS_ENH_FEAT_ADDR: rdata_nxt = enh_feat_r;
                URS_RES1_ADDR: rdata_nxt = flow_r[0];
                URS_RES2_ADDR: rdata_nxt = flow_r[1];
                URS_PAU1_ADDR: rdata_nxt = flow_r[2];
                URS_PAU2_ADDR: rdata_nxt = flow_r[3];
                URS_TRIG_ADDR: rdata_nxt = trig_r;
                URS_DLL_ADDR: rdata_nxt = dll_r;
                URS_DLH_ADDR: rdata_nxt = dlh_r;
                default: rdata_nxt = URS_ZERO_RST;
            endcase
        end
    end

    // Pin levels: modem control bits drive active-low pins
    always_comb begin
        pins_nxt.tx = 1'b1;
        pins_nxt.dtr_n = ~modem_ctl_r[URS_MCTL_DTR_BIT];
        pins_nxt.rts_n = ~modem_ctl_r[URS_MCTL_RTS_BIT];
        pins_nxt.user_output_one_n = ~modem_ctl_r[URS_MCTL_OUT1_BIT];
        pins_nxt.user_output_two_n = ~modem_ctl_r[URS_MCTL_OUT2_BIT];
        rxr_oe_nxt = ~isa_s;
        txr_oe_nxt = ~isa_s;
    end

    // Register everything; reset loads constants asynchronously
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            int_en_r <= URS_ZERO_RST;
            fifo_ctl_r <= URS_ZERO_RST;
            line_ctl_r <= URS_ZERO_RST;
            modem_ctl_r <= URS_ZERO_RST;
            scratch_r <= URS_SCRATCH_RST;
            enh_mode_r <= URS_ZERO_RST;
            enh_feat_r <= URS_ZERO_RST;
            trig_r <= URS_ZERO_RST;
            dll_r <= URS_ZERO_RST;
            dlh_r <= URS_ZERO_RST;
            for (int i = 0; i < 4; i++) begin
                flow_r[i] <= URS_ZERO_RST;
            end
            mstat_prev_r <= '0;
            mstat_delta_r <= '0;
            settle_r <= '0;
            rdata <= URS_ZERO_RST;
            pins <= '1;
            receive_ready_n <= 1'b1;
            receive_ready_oe <= 1'b1;
            transmit_ready_n <= 1'b0;
            transmit_ready_oe <= 1'b1;
            irq <= 1'b0;
            irq_oe <= 1'b1;
        end else begin
            int_en_r <= int_en_nxt;
            fifo_ctl_r <= fifo_ctl_nxt;
            line_ctl_r <= line_ctl_nxt;
            modem_ctl_r <= modem_ctl_nxt;
            scratch_r <= scratch_nxt;
            enh_mode_r <= enh_mode_nxt;
            enh_feat_r <= enh_feat_nxt;
            trig_r <= trig_nxt;
            dll_r <= dll_nxt;
            dlh_r <= dlh_nxt;
            for (int i = 0; i < 4; i++) begin
                flow_r[i] <= flow_nxt[i];
            end
            mstat_prev_r <= mstat_prev_nxt;
            mstat_delta_r <= mstat_delta_nxt;
            settle_r <= settle_nxt;
            rdata <= rdata_nxt;
            pins <= pins_nxt;
            receive_ready_n <= 1'b1;
            receive_ready_oe <= rxr_oe_nxt;
            transmit_ready_n <= 1'b0;
            transmit_ready_oe <= txr_oe_nxt;
            irq <= 1'b0;
            irq_oe <= txr_oe_nxt;
        end
    end

    // Flow character write then read returns it
    flow_rw_a: assert property (@(posedge clock) disable iff (rst)
        (req.wr && req.addr == URS_RES1_ADDR) ##1 (req.rd && req.addr == URS_RES1_ADDR)
        |=> rdata == $past(req.wdata, 2))
        else $error("resume char readback wrong");
    // Scratch read standing at reset release returns its reset value
    scratch_reset_a: assert property (@(posedge clock)
        $fell(rst) && req.rd && req.addr == URS_SCRATCH_ADDR |=> rdata == URS_SCRATCH_RST)
        else $error("scratch reset value wrong");
    // Line status constant
    status_fixed_a: assert property (@(posedge clock) disable iff (rst)
        req.rd && req.addr == URS_LINE_STAT_ADDR |=> rdata == URS_LINE_STAT_RST)
        else $error("line status wrong");
    // Modem status upper nibble follows inverted pins
    mstat_upper_a: assert property (@(posedge clock) disable iff (rst)
        req.rd && req.addr == URS_MODEM_STAT_ADDR |=> rdata[7:4] == ~$past(modem_s))
        else $error("modem status upper bits wrong");
    // Pins high while modem control is zero
    pins_idle_a: assert property (@(posedge clock) disable iff (rst)
        $past(modem_ctl_r) == URS_ZERO_RST |-> pins == '1)
        else $error("idle pin level wrong");
    // Receive-ready floats in ISA mode after two cycles
    rxr_mode_a: assert property (@(posedge clock) disable iff (rst)
        isa_s [*2] |-> !receive_ready_oe && receive_ready_n)
        else $error("receive ready mode wrong");
    // Transmit-ready and interrupt share the enable
    txr_irq_a: assert property (@(posedge clock) disable iff (rst)
        transmit_ready_oe == irq_oe && !transmit_ready_n && !irq)
        else $error("transmit ready or irq wrong");
    // Interrupt enable write takes effect at the next edge
    post_reset_a: assert property (@(posedge clock) disable iff (rst)
        req.wr && req.addr == URS_INT_EN_ADDR |=> int_en_r == $past(req.wdata))
        else $error("write after reset lost");

    flow_write_c: cover property (@(posedge clock) req.wr && req.addr == URS_PAU2_ADDR);
    mstat_change_c: cover property (@(posedge clock) mstat_delta_r != 4'h0);
    isa_mode_c: cover property (@(posedge clock) !irq_oe);
endmodule
`default_nettype wire

/* File: verification/urs_modem_model.sv */
// Purpose: Far-end modem line model for the reset-state block
// Assumes: Bench asks for line levels, model applies them after an edge
// Notes: Lines idle high, as with pull-ups on the modem inputs
`timescale 1ns/1ns
`default_nettype none
module urs_modem_model (
    input wire logic clock,
    input wire logic [3:0] level_n,
    output logic [3:0] modem_in_n
);
    // Line levels, idle high before any request
    logic [3:0] line_r = 4'hf;
    // Apply the requested levels a little after each edge
    always @(posedge clock) begin
        line_r <= #7 level_n;
    end
    assign modem_in_n = line_r;
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the reset-state register block
// Assumes: One-cycle strobes, read data in the cycle after the read
// Notes: Prints only mismatches and the verdict
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import urs_pkg::*;
    logic clock; // 20 MHz
    logic rst; // Async, active high
    urs_req_type req; // Register request
    logic [7:0] rdata; // Read data
    logic isa_mode; // Bus mode select
    logic [3:0] level_n; // Wanted modem levels
    logic [3:0] modem_in_n; // Modem pins
    urs_pins_type pins; // Serial and modem outputs
    logic rx_n, rx_oe, tx_n, tx_oe, irq, irq_oe; // Status pins
    int fails; // Mismatch count
    int checked; // Comparison count
    logic [7:0] got; // Last read value
    // Reset table: index and expected value
    logic [4:0] ra [15] = '{URS_INT_EN_ADDR, URS_INT_STAT_ADDR, URS_FIFO_CTL_ADDR,
        URS_LINE_CTL_ADDR, URS_MODEM_CTL_ADDR, URS_LINE_STAT_ADDR, URS_SCRATCH_ADDR,
        URS_ENH_MODE_ADDR, URS_FIFO_LVL_ADDR, URS_ENH_FEAT_ADDR, URS_RES1_ADDR,
        URS_RES2_ADDR, URS_PAU1_ADDR, URS_PAU2_ADDR, URS_TRIG_ADDR};
    logic [7:0] re [15] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h60, 8'hff, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    urs_regs i_urs_regs (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
        .isa_mode(isa_mode), .modem_in_n(modem_in_n), .pins(pins),
        .receive_ready_n(rx_n), .receive_ready_oe(rx_oe), .transmit_ready_n(tx_n),
        .transmit_ready_oe(tx_oe), .irq(irq), .irq_oe(irq_oe));
    urs_modem_model i_urs_modem_model (.clock(clock), .level_n(level_n),
        .modem_in_n(modem_in_n));

    // Clock generator
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Compare and report
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask
    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Write then read of one index with no idle cycle between
    task automatic wr_rd(input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        q = rdata;
    endtask
    // Release reset with a scratch read already standing at that edge
    task automatic release_rst;
        @(posedge clock);
        rst <= 1'b0;
        req <= '{addr: URS_SCRATCH_ADDR, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        chk(rdata, 8'hff);
    endtask
    // Idle output levels, oe pattern given
    task automatic pin_chk(input logic [7:0] oe);
        chk({3'h0, pins}, 8'h1f);
        chk({5'h0, rx_n, tx_n, irq}, 8'h04);
        chk({5'h0, rx_oe, tx_oe, irq_oe}, oe);
    endtask
    // Read every register except the divisor latches against its reset value
    task automatic reset_reads;
        for (int i = 0; i < 15; i++) begin
            rd(ra[i], got);
            chk(got, re[i]);
        end
        rd(URS_MODEM_STAT_ADDR, got);
        chk(got, {~level_n, 4'h0});
    endtask
    // Verdict and end of run
    task automatic wrap_up;
        if (fails == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clock);
        fails++;
        wrap_up;
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        isa_mode = 1'b0;
        level_n = 4'hf;
        req = '0;
        fails = 0;
        checked = 0;
        repeat (4) @(posedge clock);
        #1 pin_chk(8'h07);
        release_rst;
        reset_reads;
        // Flow characters, all four written, then all four read back
        for (int i = 0; i < 4; i++) begin
            wr(5'(URS_RES1_ADDR + i), 8'(8'ha5 + 17 * i));
        end
        for (int i = 0; i < 4; i++) begin
            rd(5'(URS_RES1_ADDR + i), got);
            chk(got, 8'(8'ha5 + 17 * i));
        end
        // Write followed at once by a read of the same index
        wr_rd(URS_RES1_ADDR, 8'h3c, got);
        chk(got, 8'h3c);
        wr_rd(URS_INT_EN_ADDR, 8'hc3, got);
        chk(got, 8'hc3);
        // Status register ignores writes
        wr(URS_INT_STAT_ADDR, 8'h55);
        rd(URS_INT_STAT_ADDR, got);
        chk(got, 8'h01);
        // Modem control drives the outputs low
        wr(URS_MODEM_CTL_ADDR, 8'h0f);
        repeat (2) @(posedge clock);
        #1 chk({3'h0, pins}, 8'h10);
        // Upper modem status follows the pins inverted, lower bits flag the change
        level_n <= 4'h5;
        repeat (5) @(posedge clock);
        rd(URS_MODEM_STAT_ADDR, got);
        chk(got, 8'haa);
        rd(URS_MODEM_STAT_ADDR, got);
        chk(got, 8'ha0);
        level_n <= 4'hf;
        repeat (5) @(posedge clock);
        // Reset taken between edges acts at once
        #12 rst = 1'b1;
        #1 pin_chk(8'h07);
        repeat (2) @(posedge clock);
        release_rst;
        reset_reads;
        // Other bus mode floats the status pins
        isa_mode <= 1'b1;
        repeat (5) @(posedge clock);
        #1 pin_chk(8'h00);
        wrap_up;
    end
endmodule
`default_nettype wire
